// >>> common/psatp_defs.vh
// Constants for the PWM-synced conversion trigger and bus protection block
`ifndef PSATP_DEFS_VH
`define PSATP_DEFS_VH

// Decimation of the slow conversion stream on the first phase-A module
`define PSATP_REQB_DECIM 10
`define PSATP_REQB_CNT_W 4

// Data widths
`define PSATP_VBUS_W 16
`define PSATP_CUR_W 16

// Default filter shift: weight of a new sample is 2^-shift
`define PSATP_EMA_SHIFT 3

// Fixed-point fraction bits of the feed-forward quotient
`define PSATP_FF_FRAC 15

// Operating state codes
`define PSATP_ST_RUN 2'h0
`define PSATP_ST_BUS_OV 2'h1
`define PSATP_ST_OVER_CUR 2'h2

// Reset value of the filtered bus voltage
`define PSATP_VBUS_RST 16'h0000

`endif

// >>> hw/psatp_ema.v
// Exponential moving-average filter for the sensed bus voltage
`include "psatp_defs.vh"

module psatp_ema #(
  parameter W = `PSATP_VBUS_W,
  parameter SHIFT = `PSATP_EMA_SHIFT
) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Sample strobe and data
  input wire sample_en,
  input wire [W-1:0] sample,
  // Filtered value
  output reg [W-1:0] filt_reg
);

  wire signed [W:0] diff;
  wire signed [W:0] step;
  wire signed [W+1:0] sum;
  reg [W-1:0] filt_next;

  // Arithmetic shift keeps the sign of the step, so the filter settles both ways
  assign diff = $signed({1'b0, sample}) - $signed({1'b0, filt_reg});
  assign step = diff >>> SHIFT;
  assign sum = $signed({2'b00, filt_reg}) + {step[W], step};

  always @* begin
    filt_next = filt_reg;
    if (sample_en) begin
      filt_next = sum[W-1:0];
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      filt_reg <= `PSATP_VBUS_RST;
    end else begin
      filt_reg <= filt_next;
    end
  end

endmodule // psatp_ema

// >>> hw/psatp_top.v
// PWM-synced conversion triggers with bus overvoltage, overcurrent and feed-forward
//
// Contract
// - Each down-count compare-B match of the first phase-A PWM raises its request A.
// - The same first-module event raises its request B only on every tenth match.
// - Second module: up compare-B gives A, down compare-B gives B; third: period gives A.
// - Each fast cycle the filtered bus is checked against the limit; excess trips all PWM.
// - The filtered bus comes from each fast-cycle bus sample through an average filter.
// - The filtered bus is clamped from below at a configurable minimum for feed-forward.
// - In current-loop mode the feed-forward term uses the clamped bus and controller output.
// - The current loop is fed from the sigma-delta grid current, never the converter samples.
// - With sigma-delta sensing an overcurrent check runs in every operating mode.
`include "psatp_defs.vh"

module psatp_top #(
  parameter VW = `PSATP_VBUS_W,
  parameter CW = `PSATP_CUR_W,
  parameter EMA_SHIFT = `PSATP_EMA_SHIFT,
  parameter REQB_DECIM = `PSATP_REQB_DECIM
) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Time-base events of the phase-A PWM modules, one-cycle pulses
  input wire pwm1_downcount_compare_b_match,
  input wire pwm2_upcount_compare_b_match,
  input wire pwm2_downcount_compare_b_match,
  input wire pwm3_counter_period_match,
  // Conversion-start requests to the converters, one-cycle pulses
  output reg pwm1_conversion_request_a,
  output reg pwm1_conversion_request_b,
  output reg pwm2_conversion_request_a,
  output reg pwm2_conversion_request_b,
  output reg pwm3_conversion_request_a,
  // Fast control cycle strobe and sensed data
  input wire fast_control_cycle,
  input wire [VW-1:0] vbus_sample,
  input wire signed [CW-1:0] sigma_delta_filter_path_grid_current,
  input wire signed [CW-1:0] current_ctrl_out,
  input wire signed [CW-1:0] decouple_in,
  // Configuration
  input wire [VW-1:0] vbus_ov_limit,
  input wire [VW-1:0] vbus_min,
  input wire [CW-1:0] over_current_limit,
  input wire current_loop_mode,
  input wire clear_trip,
  // Protection and conditioning results
  output reg pwm_force_off,
  output reg [1:0] op_state,
  output wire [VW-1:0] vbus_filtered,
  output reg [VW-1:0] vbus_clamped,
  output reg signed [CW-1:0] loop_current_fb,
  output reg signed [CW-1:0] ff_term,
  output reg ff_valid
);

  // Divider width comes from the header, so REQB_DECIM must fit in it
  localparam integer REQB_LAST_I = REQB_DECIM - 1;
  localparam [`PSATP_REQB_CNT_W-1:0] REQB_LAST = REQB_LAST_I[`PSATP_REQB_CNT_W-1:0];
  localparam integer FF_W = CW + 1 + `PSATP_FF_FRAC;

  // Magnitude of a signed current sample, saturated at the top for the most negative value
  function [CW-1:0] mag;
    input signed [CW-1:0] v;
    begin
      if (v[CW-1]) begin
        mag = (v == {1'b1, {(CW-1){1'b0}}}) ? {1'b0, {(CW-1){1'b1}}} : -v;
      end else begin
        mag = v;
      end
    end
  endfunction

  reg [`PSATP_REQB_CNT_W-1:0] reqb_cnt_reg;
  reg [`PSATP_REQB_CNT_W-1:0] reqb_cnt_next;
  reg reqb_fire;
  reg fast_d_reg;
  reg force_off_next;
  reg [1:0] state_next;
  reg [VW-1:0] clamp_next;
  reg signed [FF_W-1:0] num;
  reg signed [FF_W-1:0] quo;
  reg signed [CW-1:0] ff_next;
  wire [VW-1:0] filt;
  wire signed [CW:0] ff_sum;
  wire bus_ov;
  wire over_cur;

  // Decimating divider for the slow stream
  always @* begin
    reqb_cnt_next = reqb_cnt_reg;
    reqb_fire = 1'b0;
    if (pwm1_downcount_compare_b_match) begin
      if (reqb_cnt_reg == REQB_LAST) begin
        reqb_cnt_next = {`PSATP_REQB_CNT_W{1'b0}};
        reqb_fire = 1'b1;
      end else begin
        reqb_cnt_next = reqb_cnt_reg + 1'b1;
      end
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reqb_cnt_reg <= {`PSATP_REQB_CNT_W{1'b0}};
      pwm1_conversion_request_a <= 1'b0;
      pwm1_conversion_request_b <= 1'b0;
      pwm2_conversion_request_a <= 1'b0;
      pwm2_conversion_request_b <= 1'b0;
      pwm3_conversion_request_a <= 1'b0;
    end else begin
      reqb_cnt_reg <= reqb_cnt_next;
      pwm1_conversion_request_a <= pwm1_downcount_compare_b_match;
      pwm1_conversion_request_b <= reqb_fire;
      pwm2_conversion_request_a <= pwm2_upcount_compare_b_match;
      pwm2_conversion_request_b <= pwm2_downcount_compare_b_match;
      pwm3_conversion_request_a <= pwm3_counter_period_match;
    end
  end

  // Bus filter updates on the fast cycle strobe
  psatp_ema #(
    .W(VW),
    .SHIFT(EMA_SHIFT)
  ) u_ema (
    .mclk(mclk),
    .nrst(nrst),
    .sample_en(fast_control_cycle),
    .sample(vbus_sample),
    .filt_reg(filt)
  );

  assign vbus_filtered = filt;

  // Checks run one cycle after the strobe, on the freshly filtered value
  assign bus_ov = (filt > vbus_ov_limit);
  assign over_cur = (mag(sigma_delta_filter_path_grid_current) > over_current_limit);

  // Trip latch: a new fault wins over a clear in the same cycle
  always @* begin
    force_off_next = pwm_force_off;
    state_next = op_state;
    if (fast_d_reg && (bus_ov || over_cur)) begin
      force_off_next = 1'b1;
      state_next = bus_ov ? `PSATP_ST_BUS_OV : `PSATP_ST_OVER_CUR;
    end else if (clear_trip) begin
      force_off_next = 1'b0;
      state_next = `PSATP_ST_RUN;
    end
  end

  // Clamp from below at the configured minimum
  always @* begin
    clamp_next = (filt < vbus_min) ? vbus_min : filt;
  end

  // Feed-forward: (controller output + decoupling) / clamped bus, saturated
  assign ff_sum = $signed({current_ctrl_out[CW-1], current_ctrl_out}) +
                  $signed({decouple_in[CW-1], decouple_in});

  always @* begin
    num = {ff_sum, {`PSATP_FF_FRAC{1'b0}}};
    // A zero minimum could let the divisor reach zero; treat it as the smallest step
    if (vbus_clamped == {VW{1'b0}}) begin
      quo = num;
    end else begin
      quo = num / $signed({{(FF_W-VW){1'b0}}, vbus_clamped});
    end
    // Quotient is signed, so a negative term saturates at the bottom
    if (quo > $signed({{(FF_W-CW+1){1'b0}}, {(CW-1){1'b1}}})) begin
      ff_next = {1'b0, {(CW-1){1'b1}}};
    end else if (quo < $signed({{(FF_W-CW+1){1'b1}}, {(CW-1){1'b0}}})) begin
      ff_next = {1'b1, {(CW-1){1'b0}}};
    end else begin
      ff_next = quo[CW-1:0];
    end
  end

  // Trip latch starts set, so nothing switches until a clear is seen
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fast_d_reg <= 1'b0;
      pwm_force_off <= 1'b1;
      op_state <= `PSATP_ST_RUN;
    end else begin
      fast_d_reg <= fast_control_cycle;
      pwm_force_off <= force_off_next;
      op_state <= state_next;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vbus_clamped <= `PSATP_VBUS_RST;
      loop_current_fb <= {CW{1'b0}};
      ff_term <= {CW{1'b0}};
      ff_valid <= 1'b0;
    end else begin
      ff_valid <= 1'b0;
      if (fast_d_reg) begin
        vbus_clamped <= clamp_next;
      end
      // Converter current samples are noisy and have no path into the loop
      if (fast_control_cycle) begin
        loop_current_fb <= sigma_delta_filter_path_grid_current;
      end
      // Term follows the clamp update by one cycle
      if (fast_d_reg) begin
        ff_valid <= current_loop_mode;
      end
      if (ff_valid) begin
        ff_term <= ff_next;
      end
      if (!current_loop_mode) begin
        ff_term <= {CW{1'b0}};
      end
    end
  end

endmodule // psatp_top

// >>> dv/psatp_monitor.sv
// Checker bound to the trigger and bus protection block
module psatp_chk #(parameter VW = 16, parameter CW = 16) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Triggers
  input wire pwm1_downcount_compare_b_match,
  input wire pwm2_upcount_compare_b_match,
  input wire pwm1_conversion_request_a,
  input wire pwm1_conversion_request_b,
  input wire pwm2_conversion_request_a,
  // Fast cycle
  input wire fast_control_cycle,
  input wire signed [CW-1:0] sigma_delta_filter_path_grid_current,
  input wire [VW-1:0] vbus_ov_limit,
  input wire [VW-1:0] vbus_min,
  input wire pwm_force_off,
  input wire [1:0] op_state,
  input wire [VW-1:0] vbus_filtered,
  input wire [VW-1:0] vbus_clamped,
  input wire signed [CW-1:0] loop_current_fb
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Check cycle is the one after the strobe
  sequence s_chk; fast_control_cycle ##1 1'b1; endsequence
  property p_a1; pwm1_downcount_compare_b_match |=> pwm1_conversion_request_a; endproperty
  a_a1: assert property (p_a1) else $error("a1 missing");
  property p_b1; pwm1_conversion_request_b |-> $past(pwm1_downcount_compare_b_match); endproperty
  a_b1: assert property (p_b1) else $error("b1 without event");
  property p_gap; pwm1_conversion_request_b |=> !pwm1_conversion_request_b [*8]; endproperty
  a_gap: assert property (p_gap) else $error("b1 too soon");
  property p_a2; pwm2_upcount_compare_b_match |=> pwm2_conversion_request_a; endproperty
  a_a2: assert property (p_a2) else $error("a2 missing");
  property p_ov; s_chk ##0 (vbus_filtered > vbus_ov_limit) |=> pwm_force_off && op_state == 2'h1;
  endproperty
  a_ov: assert property (p_ov) else $error("no trip");
  property p_clamp; s_chk |=> vbus_clamped >= vbus_min
    && (vbus_clamped == vbus_filtered || vbus_clamped == vbus_min); endproperty
  a_clamp: assert property (p_clamp) else $error("bad clamp");
  property p_hold; !fast_control_cycle |=> $stable(vbus_filtered); endproperty
  a_hold: assert property (p_hold) else $error("filter moved");
  property p_fb; fast_control_cycle |=> loop_current_fb == $past(sigma_delta_filter_path_grid_current); endproperty
  a_fb: assert property (p_fb) else $error("bad feedback");
endmodule // psatp_chk

bind psatp_top psatp_chk #(.VW(VW), .CW(CW)) u_chk (.*);

// >>> dv/psatp_conv.sv
// Converter model: counts conversions started by the first module
module psatp_conv (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Requests
  input wire req_a,
  input wire req_b,
  // Conversions since reset
  output logic [15:0] n_a,
  output logic [15:0] n_b
);
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      n_a <= 16'h0;
      n_b <= 16'h0;
    end else begin
      n_a <= n_a + 16'(req_a);
      n_b <= n_b + 16'(req_b);
    end
  end
endmodule // psatp_conv

// >>> dv/tb.sv
// Self-checking bench for the trigger and bus protection block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, nrst = 0, fast_control_cycle = 0, clear_trip = 0, current_loop_mode = 1;
  logic pwm1_downcount_compare_b_match = 0, pwm2_upcount_compare_b_match = 0;
  logic pwm2_downcount_compare_b_match = 0, pwm3_counter_period_match = 0;
  logic [15:0] vbus_sample = 0, vbus_ov_limit = 16'h8000, vbus_min = 16'h1000, f = 0;
  logic [15:0] over_current_limit = 16'h4000, vbus_filtered, vbus_clamped, n_a, n_b;
  logic signed [15:0] sigma_delta_filter_path_grid_current = 0, current_ctrl_out = 0, decouple_in = 0;
  logic signed [15:0] loop_current_fb, ff_term;
  logic pwm1_conversion_request_a, pwm1_conversion_request_b, pwm2_conversion_request_a;
  logic pwm2_conversion_request_b, pwm3_conversion_request_a, pwm_force_off, ff_valid;
  logic [1:0] op_state;
  int err_total = 0, comparisons = 0, n1 = 0, k = 0;
  logic [4:0] tq[$];
  logic [68:0] fq[$], nt;
  psatp_top u_dut (.*);
  psatp_conv u_conv (.mclk, .nrst, .req_a(pwm1_conversion_request_a),
    .req_b(pwm1_conversion_request_b), .n_a, .n_b);
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Trip outputs are predicted on every strobe; overcurrent forces off as well
  task automatic fast(logic [15:0] s, logic signed [15:0] i);
    logic signed [16:0] d;
    logic [15:0] c;
    logic ov, oc;
    longint q;
    d = $signed({1'b0, s}) - $signed({1'b0, f});
    f = f + 16'(d >>> 3);
    c = (f > vbus_min) ? f : vbus_min;
    q = (longint'(current_ctrl_out) + decouple_in) * 32768 / longint'(c == 0 ? 16'h1 : c);
    q = q > 32767 ? 32767 : (q < -32768 ? -32768 : q);
    ov = f > vbus_ov_limit;
    oc = (i < 0 ? -int'(i) : int'(i)) > int'(over_current_limit);
    fq.push_back({f, c, i, 16'(q), ov ? 2'h1 : (oc ? 2'h2 : 2'h0), 1'b1, 1'b1, ov | oc});
    vbus_sample = s;
    sigma_delta_filter_path_grid_current = i;
    fast_control_cycle = 1;
    @(posedge mclk) #1 fast_control_cycle = 0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  always @(posedge mclk)
    if (tq.size() > 0) chk("requests", 16'(tq.pop_front()), {pwm1_conversion_request_a,
      pwm1_conversion_request_b, pwm2_conversion_request_a, pwm2_conversion_request_b,
      pwm3_conversion_request_a});
  always @(posedge mclk) begin
    if (ff_valid === 1'b1) begin
      nt = fq.pop_front();
      chk("filtered", nt[68:53], vbus_filtered);
      chk("clamped", nt[52:37], vbus_clamped);
      chk("feedback", nt[36:21], loop_current_fb);
      if (nt[2]) chk("state", 16'(nt[4:3]), 16'(op_state));
      if (nt[1]) chk("force", 16'(nt[0]), 16'(pwm_force_off));
      @(posedge mclk) chk("ff_term", nt[20:5], ff_term);
    end
  end
  initial forever #5 mclk = ~mclk;
  initial begin
    #300us;
    err_total++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h88263f17));
    repeat (10) @(posedge mclk);
    #1 nrst = 1;
    @(posedge mclk) #1;
    chk("safe start", 16'h1, 16'(pwm_force_off));
    chk("start state", 16'h0, 16'(op_state));
    clear_trip = 1;
    tq.push_back(5'h0);
    repeat (300) begin
      {pwm2_upcount_compare_b_match, pwm2_downcount_compare_b_match,
        pwm3_counter_period_match} = 3'($urandom);
      pwm1_downcount_compare_b_match = $urandom_range(3) != 0;
      n1 += pwm1_downcount_compare_b_match;
      k += pwm1_downcount_compare_b_match;
      tq.push_back({pwm1_downcount_compare_b_match, k == 10, pwm2_upcount_compare_b_match,
        pwm2_downcount_compare_b_match, pwm3_counter_period_match});
      if (k == 10) k = 0;
      @(posedge mclk) #1;
    end
    {pwm1_downcount_compare_b_match, pwm2_upcount_compare_b_match,
      pwm2_downcount_compare_b_match, pwm3_counter_period_match} = 4'h0;
    fast(16'h0800, 16'sh0);
    repeat (40) begin
      current_ctrl_out = 16'($urandom);
      decouple_in = 16'($urandom_range(16'h3fff));
      fast(16'($urandom_range(16'h7000)), 16'($urandom_range(16'h9fff)) - 16'sh5000);
    end
    repeat (24) fast(16'hffff, 16'sh0);
    clear_trip = 0;
    fast(16'hffff, 16'sh0);
    chk("latched", 16'h1, 16'(pwm_force_off));
    clear_trip = 1;
    @(posedge mclk) #1;
    chk("cleared", 16'h0, 16'(pwm_force_off));
    current_loop_mode = 0;
    fast(16'h2000, 16'sh0);
    nt = fq.pop_back();
    chk("filt no loop", nt[68:53], vbus_filtered);
    chk("ff_off", 16'h0, ff_term);
    current_loop_mode = 1;
    repeat (24) fast(16'h0, -16'sh5000);
    chk("pending", 16'h0, 16'(fq.size()));
    chk("starts a", 16'(n1), n_a);
    chk("starts b", 16'(n1 / 10), n_b);
    give_verdict();
  end
endmodule // tb
